/* asr_pkg.sv */
// Package: constants and types of the converter control and readout block
package asr_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int unsigned NUM_CHAN    = 8;
  localparam int unsigned SAMPLE_BITS = 24;
  localparam int unsigned FIFO_DEPTH  = 8;
  localparam int unsigned FIFO_WIDTH  = SAMPLE_BITS + 3;

  // ------------------------------------------------------------
  // Timing, in conversion periods and clock cycles
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS        = 20;
  localparam int unsigned RESTART_PULSE_MIN    = 1;   // CLK periods
  localparam int unsigned POWERDOWN_PULSE_MIN  = 2;   // CLK periods
  localparam int unsigned SETTLE_SPI_SYNC      = 129; // Conversions
  localparam int unsigned SETTLE_FS_SYNC       = 128;
  localparam int unsigned SETTLE_SPI_PWUP      = 130;
  localparam int unsigned SETTLE_FS_PWUP       = 129;
  localparam int unsigned CONV_PERIOD_CLKS     = 256; // Clocks per conversion

  localparam logic [7:0] PDN_CNT_MAX  = 8'(POWERDOWN_PULSE_MIN);
  localparam logic [7:0] SET_SPI_SYNC = 8'(SETTLE_SPI_SYNC);
  localparam logic [7:0] SET_FS_SYNC  = 8'(SETTLE_FS_SYNC);
  localparam logic [7:0] SET_SPI_PWUP = 8'(SETTLE_SPI_PWUP);
  localparam logic [7:0] SET_FS_PWUP  = 8'(SETTLE_FS_PWUP);
  localparam logic [4:0] BIT_LAST     = 5'(SAMPLE_BITS - 1);

  // ------------------------------------------------------------
  // Format selector codes
  // ------------------------------------------------------------
  localparam logic [2:0] FMT_SPI_TDM_DYN = 3'h0;
  localparam logic [2:0] FMT_SPI_TDM_FIX = 3'h1;
  localparam logic [2:0] FMT_SPI_DISC    = 3'h2;
  localparam logic [2:0] FMT_FS_TDM_DYN  = 3'h3;
  localparam logic [2:0] FMT_FS_TDM_FIX  = 3'h4;
  localparam logic [2:0] FMT_FS_DISC     = 3'h5;
  localparam logic [2:0] FMT_MOD         = 3'h6;

  typedef enum logic [1:0] {ASR_PROTO_SPI, ASR_PROTO_FS, ASR_PROTO_MOD, ASR_PROTO_IDLE} asr_proto_e;

  typedef enum {ASR_ST_HALT, ASR_ST_SETTLE, ASR_ST_RUN} asr_state_e;

endpackage : asr_pkg

/* asr_fifo.sv */
// Sample FIFO with parameterised width and depth
`timescale 1ns/10ps
module asr_fifo
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
)
(
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;
  logic             ready_q;
  logic [AW:0]      wr_d;
  logic [AW:0]      rd_d;

  // ------------------------------------------------------------
  // Flags
  // ------------------------------------------------------------
  // Ready is a register so the top's ready output comes from a flop
  assign in_ready  = ready_q;
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next pointers, used only to look ahead for the full flag
  always_comb
  begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  // Pointers and storage
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      wr_q    <= '0;
      rd_q    <= '0;
      ready_q <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        mem[wr_q[AW-1:0]] <= in_data;
        wr_q              <= wr_q + 1'b1;
      end
      if (pop)
        rd_q <= rd_q + 1'b1;
      // Full when pointers differ only in the wrap bit
      ready_q <= !((wr_d[AW] != rd_d[AW]) && (wr_d[AW-1:0] == rd_d[AW-1:0]));
    end
  end

endmodule : asr_fifo

/* asr_readout.sv */
// Top: restart, power-down, format decode and serial readout of the converter
//
// Operation
// RULE1 - Restart strobe low halts all channels and clears filter counters.
// RULE2 - Restart strobe high resumes all channels together on the master clock.
// RULE3 - Controller holds restart strobe low at least one clock period.
// RULE4 - SPI: ready high at restart low, low when data valid, within 129 conversions.
// RULE5 - Frame mode: outputs low from restart until valid, 127 to 128 conversions.
// RULE6 - Frame mode: controller keeps clocks running, re-pulses restart if they stop.
// RULE7 - Controller should pulse restart again after power-on once data appears.
// RULE8 - Channel powers down when its input stays low two clocks; up when high.
// RULE9 - All channels down gives micro-power state, outputs still driven.
// RULE10 - Powered-up channel valid after 129-130 (SPI) or 128-129 (frame) conversions.
// RULE11 - Powered-up channels come out aligned, no restart pulse needed.
// RULE12 - Fixed TDM slots carry zeros when down; dynamic slots pack downward.
// RULE13 - Discrete mode: powered-down channel output is always zero.
// RULE14 - Dynamic TDM: new channel joins frame only when its data is ready.
// RULE15 - Three-bit format selector decodes protocol, output mode and slot mode.
// RULE16 - SPI read-only; falling ready marks data, MSB first on falling serial clock.
// RULE17 - Controller must not use SPI above 27 MHz master clock.
// RULE18 - Chain input captured on each falling serial clock edge.
// RULE19 - Controller captures output bits on rising serial clock edge.
// RULE20 - Serial clock up to master clock; may stop between conversions in SPI.
// RULE21 - Controller waits one clock after ready falls before first rising edge.
// RULE22 - Serial clock ratio to master clock should be power of two.
// RULE23 - SPI ready returns high on first falling edge; pulses high before next data.
// RULE24 - New data loaded one clock before ready falls, overwriting unread data; here the load and the ready fall share one clock.
// RULE25 - Reserved selector code 111 holds serial outputs idle low.
`timescale 1ns/10ps
module asr_readout
  import asr_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   srst,
  input  wire logic                   restart_n,
  input  wire logic [NUM_CHAN-1:0]    chan_power_down_n,
  input  wire logic [2:0]             format_sel,
  input  wire logic                   sclk,
  input  wire logic                   frame_strobe,
  input  wire logic                   chain_in,
  input  wire logic [SAMPLE_BITS-1:0] sample_data,
  input  wire logic [2:0]             sample_chan,
  input  wire logic                   sample_valid,
  output logic                        sample_ready,
  output logic                        data_ready_n,
  output logic [NUM_CHAN-1:0]         dout,
  output logic                        micro_power,
  output logic [NUM_CHAN-1:0]         chan_active,
  output logic                        conv_run
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                         rst_s;
    logic [1:0]                         sclk_s;
    logic [1:0]                         fs_s;
    logic [1:0]                         chn_s;
    logic [NUM_CHAN-1:0]                pd_s1;
    logic [NUM_CHAN-1:0]                pd_s2;
    logic                               sclk_prev;
    logic                               fs_prev;
    logic [NUM_CHAN*2-1:0]              pdn_cnt;
    logic [NUM_CHAN-1:0]                pdn;
    logic [NUM_CHAN-1:0]                ready;
    logic [NUM_CHAN*8-1:0]              wait_cnt;
    asr_state_e                         st;
    logic [7:0]                         settle;
    logic [7:0]                         div;
    logic [NUM_CHAN*SAMPLE_BITS-1:0]    latest;
    logic [NUM_CHAN*SAMPLE_BITS-1:0]    shreg;
    logic [NUM_CHAN-1:0]                slot_en;
    logic [2:0]                         slot;
    logic [4:0]                         bitn;
    logic                               chain_phase;
    logic                               data_ready_n_n;
    logic [NUM_CHAN-1:0]                dout;
    logic                               micro;
    logic                               run;
  } asr_state_s;

  asr_state_s       s_q;
  asr_state_s       s_d;
  asr_proto_e       proto;
  logic             tdm;
  logic             dyn;
  logic             sclk_fall;
  logic             fs_rise;
  logic             conv_tick;
  logic [FIFO_WIDTH-1:0] f_data;
  logic             f_valid;
  logic             f_pop;

  // ------------------------------------------------------------
  // Format decode
  // ------------------------------------------------------------
  function automatic asr_proto_e fmt_proto(input logic [2:0] f);
    case (f)
      FMT_SPI_TDM_DYN, FMT_SPI_TDM_FIX, FMT_SPI_DISC: fmt_proto = ASR_PROTO_SPI;
      FMT_FS_TDM_DYN, FMT_FS_TDM_FIX, FMT_FS_DISC:    fmt_proto = ASR_PROTO_FS;
      FMT_MOD:                                        fmt_proto = ASR_PROTO_MOD;
      default:                                        fmt_proto = ASR_PROTO_IDLE;
    endcase
  endfunction : fmt_proto

  // Next active channel at or above a slot, honouring the slot enables
  function automatic logic [3:0] next_slot(input logic [NUM_CHAN-1:0] en, input logic [3:0] from);
    next_slot = 4'(NUM_CHAN);
    for (int i = NUM_CHAN - 1; i >= 0; i--)
      if (en[i] && (4'(i) >= from))
        next_slot = 4'(i);
  endfunction : next_slot

  always_comb
  begin
    proto = fmt_proto(format_sel); // RULE15
    tdm   = (format_sel == FMT_SPI_TDM_DYN) || (format_sel == FMT_SPI_TDM_FIX) ||
            (format_sel == FMT_FS_TDM_DYN) || (format_sel == FMT_FS_TDM_FIX); // RULE15
    dyn   = (format_sel == FMT_SPI_TDM_DYN) || (format_sel == FMT_FS_TDM_DYN); // RULE15
  end

  // Edge detection only on the second synchroniser stage
  assign sclk_fall = s_q.sclk_prev && !s_q.sclk_s[1];
  assign fs_rise   = !s_q.fs_prev && s_q.fs_s[1];
  assign conv_tick = (s_q.div == 8'(CONV_PERIOD_CLKS - 1));

  // ------------------------------------------------------------
  // Sample FIFO: converter results wait here until a conversion tick
  // ------------------------------------------------------------
  // One word per conversion; a halt empties the FIFO through its reset
  assign f_pop = conv_tick && (s_q.st == ASR_ST_RUN);

  asr_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .srst      (srst || (s_q.st == ASR_ST_HALT)),
    .in_data   ({sample_chan, sample_data}),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    logic [3:0] nxt;
    logic [7:0] wc;
    logic [1:0] pc;
    logic       spi;
    nxt = '0;
    wc  = '0;
    pc  = '0;
    spi = (proto == ASR_PROTO_SPI);
    s_d = s_q;

    // Two-stage synchronisers for restart, serial clock, strobe, chain and power-down inputs
    s_d.rst_s     = {s_q.rst_s[0], restart_n};
    s_d.sclk_s    = {s_q.sclk_s[0], sclk};
    s_d.fs_s      = {s_q.fs_s[0], frame_strobe};
    s_d.chn_s     = {s_q.chn_s[0], chain_in};
    s_d.pd_s1     = chan_power_down_n;
    s_d.pd_s2     = s_q.pd_s1;
    s_d.sclk_prev = s_q.sclk_s[1];
    s_d.fs_prev   = s_q.fs_s[1];

    // Power-down: low for the minimum width enters, high leaves at once
    for (int c = 0; c < NUM_CHAN; c++)
    begin
      pc = s_q.pdn_cnt[c*2 +: 2];
      if (s_q.pd_s2[c])
      begin
        pc         = '0;
        s_d.pdn[c] = 1'b0; // RULE8
      end
      else if (2'(pc) != PDN_CNT_MAX[1:0])
        pc = pc + 2'h1;
      if (!s_q.pd_s2[c] && (pc == PDN_CNT_MAX[1:0]))
        s_d.pdn[c] = 1'b1; // RULE8
      s_d.pdn_cnt[c*2 +: 2] = pc;
    end
    s_d.micro = &s_q.pdn; // RULE9

    // Conversion timebase shared by all channels keeps them aligned
    s_d.div = conv_tick ? 8'h00 : s_q.div + 8'h01; // RULE11

    // Per-channel wake-up latency
    for (int c = 0; c < NUM_CHAN; c++)
    begin
      wc = s_q.wait_cnt[c*8 +: 8];
      if (s_q.pdn[c])
      begin
        s_d.ready[c] = 1'b0;
        wc           = spi ? SET_SPI_PWUP : SET_FS_PWUP; // RULE10
      end
      else if (conv_tick && !s_q.ready[c] && (s_q.st == ASR_ST_RUN))
      begin
        if (wc <= 8'h01)
          s_d.ready[c] = 1'b1; // RULE10 RULE11
        else
          wc = wc - 8'h01;
      end
      s_d.wait_cnt[c*8 +: 8] = wc;
    end

    // Restart sequencing
    case (s_q.st)
      ASR_ST_HALT:
      begin
        s_d.div = '0; // RULE1
        if (s_q.rst_s[1])
        begin
          s_d.st     = ASR_ST_SETTLE; // RULE2
          s_d.settle = spi ? SET_SPI_SYNC : SET_FS_SYNC;
        end
      end
      ASR_ST_SETTLE:
      begin
        if (conv_tick)
        begin
          if (s_q.settle <= 8'h01)
          begin
            s_d.st    = ASR_ST_RUN;
            s_d.ready = ~s_q.pdn; // RULE4 RULE5
          end
          else
            s_d.settle = s_q.settle - 8'h01;
        end
      end
      ASR_ST_RUN: ;
      default: s_d.st = ASR_ST_HALT;
    endcase
    if (!s_q.rst_s[1])
    begin
      s_d.st       = ASR_ST_HALT; // RULE1
      s_d.ready    = '0;
      s_d.wait_cnt = {NUM_CHAN{SET_SPI_PWUP}};
      s_d.data_ready_n_n   = 1'b1; // RULE4
      s_d.dout     = '0; // RULE5
      s_d.latest   = '0;
    end

    // Latest result per channel
    if (f_pop && f_valid)
      s_d.latest[f_data[SAMPLE_BITS +: 3]*SAMPLE_BITS +: SAMPLE_BITS] = f_data[SAMPLE_BITS-1:0];

    // Frame load: SPI on the conversion tick, frame mode on strobe rise
    if ((s_q.st == ASR_ST_RUN) && ((spi && conv_tick) || ((proto == ASR_PROTO_FS) && fs_rise)))
    begin
      for (int c = 0; c < NUM_CHAN; c++)
        s_d.shreg[c*SAMPLE_BITS +: SAMPLE_BITS] =
          s_q.ready[c] ? s_q.latest[c*SAMPLE_BITS +: SAMPLE_BITS] : '0; // RULE12 RULE13 RULE24
      s_d.slot_en     = dyn ? s_q.ready : {NUM_CHAN{1'b1}}; // RULE12 RULE14
      nxt             = next_slot(s_d.slot_en, 4'h0);
      s_d.slot        = nxt[2:0];
      s_d.chain_phase = nxt[3];
      s_d.bitn        = '0;
      s_d.data_ready_n_n      = !spi; // RULE16
    end
    else if (sclk_fall)
    begin
      s_d.data_ready_n_n = 1'b1; // RULE23
      // Shift MSB first, chain bits enter at the bottom of channel 0
      // TDM moves only the slot on the pin; shifting the rest
      // would empty later slots before their turn
      for (int c = 0; c < NUM_CHAN; c++)
        if (!tdm || (3'(c) == s_q.slot))
          s_d.shreg[c*SAMPLE_BITS +: SAMPLE_BITS] =
            {s_q.shreg[c*SAMPLE_BITS +: SAMPLE_BITS-1], (c == 0) ? s_q.chn_s[1] : 1'b0}; // RULE16 RULE18
      if (tdm && !s_q.chain_phase && (s_q.bitn == BIT_LAST))
      begin
        nxt             = next_slot(s_q.slot_en, 4'(s_q.slot) + 4'h1); // RULE12
        s_d.slot        = nxt[2:0];
        s_d.chain_phase = nxt[3];
        s_d.bitn        = '0;
      end
      else if (s_q.bitn != BIT_LAST)
        s_d.bitn = s_q.bitn + 5'h01;
    end

    // Pulse high before the next load; a shift in this cycle is kept
    if ((s_q.st == ASR_ST_RUN) && spi && (s_q.div == 8'(CONV_PERIOD_CLKS - 2)))
      s_d.data_ready_n_n = 1'b1; // RULE23

    // Output pins
    if (s_q.st != ASR_ST_RUN)
      s_d.dout = '0; // RULE5
    else if (proto == ASR_PROTO_MOD || proto == ASR_PROTO_IDLE)
      s_d.dout = '0; // RULE25
    else if (tdm)
    begin
      s_d.dout = '0;
      // After the last slot the chain input streams through directly
      s_d.dout[0] = s_d.chain_phase ? s_q.chn_s[1] :
                    s_d.shreg[32'(s_d.slot)*SAMPLE_BITS + SAMPLE_BITS - 1]; // RULE12 RULE14
    end
    else
      for (int c = 0; c < NUM_CHAN; c++)
        s_d.dout[c] = s_q.ready[c] && s_d.shreg[c*SAMPLE_BITS + SAMPLE_BITS - 1]; // RULE13
    if (s_q.micro)
      s_d.dout = '0; // RULE9
    if (!spi)
      s_d.data_ready_n_n = 1'b1;
    // Run flag kept in its own flop so the output needs no decode
    s_d.run = (s_d.st == ASR_ST_RUN); // RULE2
  end

  // ------------------------------------------------------------
  // Register
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s_q          <= '0;
      s_q.st       <= ASR_ST_HALT;
      s_q.data_ready_n_n   <= 1'b1;
      s_q.wait_cnt <= {NUM_CHAN{SET_SPI_PWUP}};
      // Power-down pins idle high; a zero here would fake a power-down after reset
      s_q.pd_s1    <= '1;
      s_q.pd_s2    <= '1;
    end
    else
      s_q <= s_d;
  end

  // Outputs straight from flip-flops
  // Sample ready comes from the register inside the FIFO
  assign data_ready_n = s_q.data_ready_n_n;
  assign dout         = s_q.dout;
  assign micro_power  = s_q.micro;
  assign chan_active  = s_q.ready;
  assign conv_run     = s_q.run;

endmodule : asr_readout

/* asr_readout_assertions.sv */
// Checker of the converter control and readout top ports
`timescale 1ns/10ps
module asr_readout_checker
  import asr_pkg::*;
(
  input wire logic                   clock,
  input wire logic                   srst,
  input wire logic                   restart_n,
  input wire logic [NUM_CHAN-1:0]    chan_power_down_n,
  input wire logic [2:0]             format_sel,
  input wire logic                   sclk,
  input wire logic                   frame_strobe,
  input wire logic                   chain_in,
  input wire logic [SAMPLE_BITS-1:0] sample_data,
  input wire logic [2:0]             sample_chan,
  input wire logic                   sample_valid,
  input wire logic                   sample_ready,
  input wire logic                   data_ready_n,
  input wire logic [NUM_CHAN-1:0]    dout,
  input wire logic                   micro_power,
  input wire logic [NUM_CHAN-1:0]    chan_active,
  input wire logic                   conv_run
);
  // ----------------------------------------------------------
  // Settle counter and properties
  // ----------------------------------------------------------
  localparam int SET_MIN = 32256; // Slack for pin sync
  localparam int SET_MAX = 33296;
  logic [15:0] cnt_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  // Cycles since restart release; micro power clears it, while the settle count keeps running
  always_ff @(posedge clock)
  begin
    if (srst || !restart_n || conv_run || micro_power)
      cnt_q <= 16'h0;
    else
      cnt_q <= cnt_q + 16'h1;
  end

  // Restart steps and format groups
  sequence s_held_low; !restart_n [*5]; endsequence
  sequence s_non_spi; (format_sel > FMT_SPI_DISC) [*4]; endsequence
  sequence s_idle_fmt; (format_sel >= FMT_MOD) [*4]; endsequence
  sequence s_discrete; (format_sel == FMT_SPI_DISC || format_sel == FMT_FS_DISC) [*4]; endsequence

  property p_halt_stop; s_held_low |-> !conv_run; endproperty
  a_halt_stop: assert property (p_halt_stop) else $error("run flag high in restart");
  property p_resume; $rose(conv_run) |-> restart_n && cnt_q >= SET_MIN; endproperty
  a_resume: assert property (p_resume) else $error("run resumed too early");
  property p_halt_ready; s_held_low |-> data_ready_n; endproperty
  a_halt_ready: assert property (p_halt_ready) else $error("ready low in restart");
  property p_halt_dout; s_held_low |-> dout == '0; endproperty
  a_halt_dout: assert property (p_halt_dout) else $error("data driven in restart");
  property p_settle_max; cnt_q <= SET_MAX; endproperty
  a_settle_max: assert property (p_settle_max) else $error("settling too long");
  property p_pd_off; (chan_active & ~chan_power_down_n & ~$past(chan_power_down_n, 8)) == '0; endproperty
  a_pd_off: assert property (p_pd_off) else $error("channel active while powered down");
  property p_micro; ~|chan_power_down_n && ~|$past(chan_power_down_n, 8) |-> micro_power && chan_active == '0;
  endproperty
  a_micro: assert property (p_micro) else $error("no micro power");
  property p_kept; restart_n && $past(restart_n, 8) |->
    ($past(chan_active) & ~chan_active & chan_power_down_n & $past(chan_power_down_n, 8)) == '0; endproperty
  a_kept: assert property (p_kept) else $error("running channel dropped");
  property p_disc_zero; s_discrete |-> (dout & ~chan_power_down_n & ~$past(chan_power_down_n, 8)) == '0;
  endproperty
  a_disc_zero: assert property (p_disc_zero) else $error("data on powered-down pin");
  property p_ready_release; !data_ready_n && $fell(sclk) |-> ##[1:6] data_ready_n; endproperty
  a_ready_release: assert property (p_ready_release) else $error("ready not released");
  property p_ready_fall; $fell(data_ready_n) |-> conv_run; endproperty
  a_ready_fall: assert property (p_ready_fall) else $error("ready fell while settling");
  property p_fmt_proto; s_non_spi |-> data_ready_n; endproperty
  a_fmt_proto: assert property (p_fmt_proto) else $error("ready low in frame format");
  property p_fmt_idle; s_idle_fmt |-> dout == '0; endproperty
  a_fmt_idle: assert property (p_fmt_idle) else $error("data in idle format");
endmodule : asr_readout_checker

/* asr_host_model.sv */
// Host controller model: serial clock, frame strobe and word capture
`timescale 1ns/10ps
module asr_host_model
(
  input  wire logic       clock,
  input  wire logic       data_ready_n,
  input  wire logic [7:0] dout,
  input  wire logic [2:0] lane,
  input  wire logic       start,
  output logic            sclk,
  output logic            frame_strobe,
  output logic            chain_in,
  output logic [23:0]     rx_word,
  output logic            done
);
  // Idle levels
  initial
  begin
    sclk         = 1'b0;
    frame_strobe = 1'b0;
    chain_in     = 1'b0;
    rx_word      = 24'h0;
    done         = 1'b1;
  end

  // Frame strobe runs free at one conversion period
  always
  begin
    repeat (128) @(posedge clock);
    #1 frame_strobe = ~frame_strobe;
  end

  // One word per request; serial clock stands low between words
  always @(posedge start)
  begin
    done = 1'b0;
    @(negedge data_ready_n);
    repeat (3) @(posedge clock);
    for (int i = 0; i < 24; i++)
    begin
      #1 sclk = 1'b1;
      rx_word = {rx_word[22:0], dout[lane]};
      chain_in = ~chain_in;
      repeat (2) @(posedge clock);
      #1 sclk = 1'b0;
      repeat (6) @(posedge clock);
    end
    done = 1'b1;
  end
endmodule : asr_host_model

/* asr_testbench.sv */
// Self-checking testbench of the converter control and readout block
`timescale 1ns/10ps
module testbench;
  import asr_pkg::*;
  // ----------------------------------------------------------
  // Stimulus, model state and instances
  // ----------------------------------------------------------
  logic                   clock, sready, data_ready_n_n, micro, run, sclk, fstrobe, chain, done;
  logic                   srst = 1'b1, restart_n = 1'b1, feed = 1'b0, start = 1'b0, svalid = 1'b0;
  logic [NUM_CHAN-1:0]    pwr_n = 8'hFF, dout, chan_active;
  logic [2:0]             fmt = 3'h0, schan = 3'h0, lane = 3'h0;
  logic [SAMPLE_BITS-1:0] sdata = 24'h0, val = 24'h0, rx;
  logic [SAMPLE_BITS-1:0] exp_q[$];
  int                     fails = 0, n_checks = 0, n_acc = 0, cyc = 0, n0, t, lo, hi;

  asr_readout uut (.clock(clock), .srst(srst), .restart_n(restart_n), .chan_power_down_n(pwr_n),
    .format_sel(fmt), .sclk(sclk), .frame_strobe(fstrobe), .chain_in(chain), .sample_data(sdata),
    .sample_chan(schan), .sample_valid(svalid), .sample_ready(sready), .data_ready_n(data_ready_n_n),
    .dout(dout), .micro_power(micro), .chan_active(chan_active), .conv_run(run));
  asr_host_model host (.clock(clock), .data_ready_n(data_ready_n_n), .dout(dout), .lane(lane), .start(start),
    .sclk(sclk), .frame_strobe(fstrobe), .chain_in(chain), .rx_word(rx), .done(done));

  // System clock; the SPI clock limit binds a converter clock, not this model
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Accepted words and ceiling; two full settles dominate the run
  always @(posedge clock)
  begin
    cyc++;
    if (svalid === 1'b1 && sready === 1'b1) n_acc++;
    if (cyc == 95000)
    begin
      fails++;
      finish_test();
    end
  end

  // Sample feeder; channel steps with each accepted word
  always @(negedge clock)
  begin
    svalid = feed;
    sdata  = val;
    schan  = 3'(n_acc);
  end

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // Bounded wait for run and all channels settled
  task automatic wait_run(output int n);
    n = 0;
    while ((run !== 1'b1 || chan_active !== 8'hFF) && n < 34000)
    begin
      @(negedge clock);
      n++;
    end
  endtask : wait_run

  // Drain, refill until refused, then let every channel take the new value
  task automatic load(input logic [SAMPLE_BITS-1:0] v);
    feed = 1'b0;
    repeat (9 * CONV_PERIOD_CLKS) @(negedge clock);
    check(sready, 1'b1, "fifo not drained");
    val  = v;
    feed = 1'b1;
    n0   = n_acc;
    repeat (24) @(negedge clock);
    check(32'(n_acc - n0 >= FIFO_DEPTH && n_acc - n0 <= FIFO_DEPTH + 1), 32'h1, "fifo depth");
    check(sready, 1'b0, "fifo never full");
    repeat (10 * CONV_PERIOD_CLKS) @(negedge clock);
  endtask : load

  // One serial word from one pin against the queued expectation
  task automatic read_lane(input logic [2:0] l, input logic [SAMPLE_BITS-1:0] e);
    lane = l;
    exp_q.push_back(e);
    start = 1'b1;
    @(negedge clock);
    for (int n = 0; n < 2000 && done !== 1'b1; n++) @(negedge clock);
    start = 1'b0;
    check(rx, exp_q.pop_front(), "serial word");
    @(negedge clock);
  endtask : read_lane

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial
  begin
    void'($urandom(32'h44d0));
    lo = (SETTLE_FS_SYNC - 2) * CONV_PERIOD_CLKS;
    hi = SETTLE_SPI_PWUP * CONV_PERIOD_CLKS + 16;
    repeat (16) @(negedge clock);
    check(data_ready_n_n, 1'b1, "ready low in reset");
    check({dout, chan_active, micro, run}, 18'h0, "outputs in reset");
    srst = 1'b0;
    wait_run(t);
    check(run, 1'b1, "no run after reset");
    load(24'($urandom));
    read_lane(3'h0, val);
    read_lane(3'h0, val);
    for (int c = 0; c < 8; c++)
    begin
      fmt = 3'(c);
      repeat (8) @(negedge clock);
      if (c > 2) check(data_ready_n_n, 1'b1, "ready low in frame format");
      if (c > 5) check(dout, 8'h0, "data in idle format");
    end
    fmt = FMT_SPI_DISC;
    pwr_n[3] = 1'b0;
    repeat (10) @(negedge clock);
    check(chan_active, 8'hF7, "channel power-down");
    load(24'($urandom));
    check(chan_active, 8'hF7, "other channels disturbed");
    read_lane(3'h0, val);
    read_lane(3'h3, 24'h0);
    fmt = FMT_SPI_TDM_DYN;
    restart_n = 1'b0;
    repeat (10) @(negedge clock);
    check(data_ready_n_n, 1'b1, "ready low in restart");
    check({dout, run}, 9'h0, "data or run in restart");
    pwr_n = 8'h00;
    repeat (10) @(negedge clock);
    check({micro, chan_active}, 9'h100, "no micro power");
    pwr_n = 8'hFF;
    restart_n = 1'b1;
    wait_run(t);
    check(32'(t >= lo && t <= hi), 32'h1, "settle time");
    finish_test();
  end
endmodule : testbench

bind asr_readout asr_readout_checker chk (.clock(clock), .srst(srst), .restart_n(restart_n),
  .chan_power_down_n(chan_power_down_n), .format_sel(format_sel), .sclk(sclk), .frame_strobe(frame_strobe),
  .chain_in(chain_in), .sample_data(sample_data), .sample_chan(sample_chan), .sample_valid(sample_valid),
  .sample_ready(sample_ready), .data_ready_n(data_ready_n), .dout(dout), .micro_power(micro_power),
  .chan_active(chan_active), .conv_run(conv_run));
